//--- pkg/rs_dec_pkg.sv
// Constants, state type and GF(256) arithmetic for the byte-wide RS decoder.
// Assumes the field polynomial and first root below; shared by design and bench.
package rs_dec_pkg;

  localparam logic [8:0] GF_POLY = 9'h187;
  localparam logic [7:0] GF_ALPHA = 8'h02;
  localparam int FIRST_ROOT = 120;
  localparam int MAX_CHECK = 20;
  localparam int MIN_CHECK = 2;
  localparam int MAX_BLOCK = 255;
  localparam int FIELD_ORDER = 255;

  // Order of the initialization bytes after the init reset falls
  localparam logic [2:0] INIT_IDX_LEN = 3'h0;
  localparam logic [2:0] INIT_IDX_CHECK = 3'h1;
  localparam logic [2:0] INIT_IDX_THR = 3'h2;
  localparam logic [2:0] INIT_IDX_CTRL = 3'h3;
  localparam logic [2:0] INIT_IDX_DONE = 3'h4;

  // Control byte bit positions
  localparam int CTRL_ERASE_REJECT = 0;
  localparam int CTRL_CORR_VEC = 1;
  localparam int CTRL_REVERSE = 2;
  localparam int CTRL_WITH_CHECKS = 3;

  localparam logic [7:0] RST_LEN = 8'hFF;
  localparam logic [4:0] RST_CHECK = 5'h14;
  localparam logic [4:0] RST_THR = 5'h14;
  localparam logic [3:0] RST_CTRL = 4'h0;

  // Avalon-MM byte addresses and field positions
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_BLOCKS = 4'h8;
  localparam int CFG_LEN_LSB = 0;
  localparam int CFG_CHECK_LSB = 8;
  localparam int CFG_THR_LSB = 16;
  localparam int CFG_CTRL_LSB = 24;
  localparam int STS_ERS_LSB = 0;
  localparam int STS_DEG_LSB = 8;
  localparam int STS_STATE_LSB = 16;
  localparam int STS_FLAG_BIT = 24;
  localparam int STS_DISCARD_BIT = 25;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_ERAS = 3'b001,
    ST_SETUP = 3'b010,
    ST_BM = 3'b011,
    ST_OMEGA = 3'b100,
    ST_CHIEN = 3'b101,
    ST_JUDGE = 3'b110,
    ST_OUT = 3'b111
  } dec_state_t;

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY[7:0] : 8'h00);
      if (b[i]) begin
        p = p ^ a;
      end
    end
    return p;
  endfunction : gf_mul

  function automatic logic [7:0] gf_pow(input logic [7:0] base, input int e);
    logic [7:0] r;
    r = 8'h01;
    for (int i = 0; i < FIELD_ORDER; i++) begin
      if (i < e) begin
        r = gf_mul(r, base);
      end
    end
    return r;
  endfunction : gf_pow

  // a^254; long combinational chain, fine at the system clock rate
  function automatic logic [7:0] gf_inv(input logic [7:0] a);
    logic [7:0] t;
    t = a;
    for (int i = 0; i < 6; i++) begin
      t = gf_mul(gf_mul(t, t), a);
    end
    return gf_mul(t, t);
  endfunction : gf_inv

endpackage : rs_dec_pkg

//--- rtl/rs_decoder_io_and_erasure_control.sv
// Byte-wide RS decoder: init byte capture, erasure-aware BM, Chien/Forney, output port.
// Assumes synchronous host pins on sys_clk_i and an Avalon-MM master for the registers.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Threshold above check count acts as check count
// - Threshold and check count loaded separately, max 20
// - Equal threshold flags only beyond full capability
// - Lower threshold flags earlier; needs erasures
// - Correct when erasures plus twice errors fit
// - Too many erasures: drop marks, errors only
// - Fully static state, clock may stop
// - Config byte taken when init and strobe low
// - Config bytes accepted every clock
// - Data byte latched on strobe and ready
// - Init low routes byte to config
// - Bytes while not ready are ignored
// - Erasure mark sampled with each byte
// - Output bus comes from a register
// - Ack ignored while output not valid
// - Each ack before the last byte advances the output pointer
// - Flag valid at first forward byte
// - Flag valid at last reverse byte
// - Flag low correctable, high beyond threshold
// - Check count programmable from 2 to 20
// - Field polynomial x8+x7+x2+x+1
// - Generator roots alpha^120 onward
// - Output corrected bytes or correction vectors
module rs_decoder_io_and_erasure_control #(
  parameter int MAX_N = 255,
  parameter int MAX_R = 20
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic init_reset_n_i,
  input wire logic input_strobe_n_i,
  input wire logic [7:0] input_byte_bus_i,
  input wire logic erasure_mark_i,
  output logic input_ready_o,
  output logic [7:0] output_byte_bus_o,
  output logic output_valid_o,
  input wire logic output_ack_i,
  output logic correctable_flag_n_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  rs_dec_pkg::dec_state_t state_ff;
  logic [7:0] cfg_len_ff, idx_ff, xpow_ff, xb_ff, dout_ff, optr_ff;
  logic [4:0] cfg_check_ff, cfg_thr_ff, k_ff;
  logic [3:0] cfg_ctrl_ff;
  logic [2:0] init_idx_ff;
  logic [7:0] mem_ff [MAX_N];
  logic mark_ff [MAX_N];
  logic [7:0] syn_ff [MAX_R], omg_ff [MAX_R], root_w [MAX_R];
  logic [7:0] lam_ff [MAX_R+1], bpoly_ff [MAX_R+1], ainv_w [MAX_R+1];
  logic [5:0] ers_ff, era_used_ff, deg_ff, root_cnt_ff;
  logic discard_ff, ready_ff, valid_ff, flag_n_ff, wait_ff;
  logic [15:0] blocks_ff;
  logic [31:0] rdata_ff;

  logic cfg_take, data_take, av_cfg_wr, is_root, judge_fail, out_done;
  logic [4:0] peff, limit;
  logic [7:0] conv_val, lam_sum, odd_sum, omg_sum, err_val;
  logic [7:0] out_cnt, out_first, out_last, out_next;

  localparam logic [7:0] AINV_FCR =
    rs_dec_pkg::gf_pow(rs_dec_pkg::GF_ALPHA, rs_dec_pkg::FIELD_ORDER - rs_dec_pkg::FIRST_ROOT);

  // Field constants per coefficient position
  for (genvar j = 0; j < MAX_R; j++) begin : g_root
    assign root_w[j] = rs_dec_pkg::gf_pow(rs_dec_pkg::GF_ALPHA, rs_dec_pkg::FIRST_ROOT + j);
  end
  for (genvar i = 0; i <= MAX_R; i++) begin : g_ainv
    assign ainv_w[i] = rs_dec_pkg::gf_pow(rs_dec_pkg::GF_ALPHA, (rs_dec_pkg::FIELD_ORDER - i) %
                                          rs_dec_pkg::FIELD_ORDER);
  end

  assign cfg_take = ~init_reset_n_i & ~input_strobe_n_i;
  assign data_take = init_reset_n_i & ~input_strobe_n_i & ready_ff &
                     (state_ff == rs_dec_pkg::ST_LOAD);
  assign av_cfg_wr = avs_write_i & ~wait_ff & (avs_address_i == rs_dec_pkg::ADDR_CONFIG);
  assign peff = (cfg_thr_ff > cfg_check_ff) ? cfg_check_ff : cfg_thr_ff;
  // Excess-erasure blocks are judged against full capability
  assign limit = discard_ff ? cfg_check_ff : peff;

  // Sum of lam[i]*syn[k-i]; discrepancy in BM, evaluator coefficient after
  always_comb begin
    conv_val = 8'h00;
    for (int i = 0; i <= MAX_R; i++) begin
      if (5'(i) <= k_ff && i < MAX_R) begin
        conv_val = conv_val ^ rs_dec_pkg::gf_mul(lam_ff[i], syn_ff[5'(k_ff - 5'(i))]);
      end
    end
  end

  // Chien sums; lam and omg hold terms scaled by X^-i
  always_comb begin
    lam_sum = 8'h00;
    odd_sum = 8'h00;
    omg_sum = 8'h00;
    for (int i = 0; i <= MAX_R; i++) begin
      lam_sum = lam_sum ^ lam_ff[i];
      if (i % 2 == 1) begin
        odd_sum = odd_sum ^ lam_ff[i];
      end
      if (i < MAX_R) begin
        omg_sum = omg_sum ^ omg_ff[i];
      end
    end
  end

  assign is_root = (lam_sum == 8'h00);
  // Forney with first root 120: X^-120 * Omega(X^-1) / (X^-1 Lambda'(X^-1))
  assign err_val = is_root ?
    rs_dec_pkg::gf_mul(rs_dec_pkg::gf_mul(xb_ff, omg_sum), rs_dec_pkg::gf_inv(odd_sum)) :
    8'h00;

  assign judge_fail = (root_cnt_ff != deg_ff) ||
                      (7'({deg_ff, 1'b0}) - 7'(era_used_ff) > 7'(limit)) ||
                      (discard_ff & ~cfg_ctrl_ff[rs_dec_pkg::CTRL_ERASE_REJECT]);

  assign out_cnt = cfg_ctrl_ff[rs_dec_pkg::CTRL_WITH_CHECKS] ? cfg_len_ff :
                   8'(cfg_len_ff - 8'(cfg_check_ff));
  assign out_first = cfg_ctrl_ff[rs_dec_pkg::CTRL_REVERSE] ? 8'(out_cnt - 8'h01) : 8'h00;
  assign out_last = cfg_ctrl_ff[rs_dec_pkg::CTRL_REVERSE] ? 8'h00 : 8'(out_cnt - 8'h01);
  assign out_next = cfg_ctrl_ff[rs_dec_pkg::CTRL_REVERSE] ? 8'(optr_ff - 8'h01) :
                    8'(optr_ff + 8'h01);
  assign out_done = valid_ff & output_ack_i & (optr_ff == out_last);

  // Configuration: init bytes win over a same-cycle bus write
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_len_ff <= rs_dec_pkg::RST_LEN;
      cfg_check_ff <= rs_dec_pkg::RST_CHECK;
      cfg_thr_ff <= rs_dec_pkg::RST_THR;
      cfg_ctrl_ff <= rs_dec_pkg::RST_CTRL;
      init_idx_ff <= rs_dec_pkg::INIT_IDX_LEN;
    end else if (init_reset_n_i) begin
      init_idx_ff <= rs_dec_pkg::INIT_IDX_LEN;
      if (av_cfg_wr) begin
        cfg_len_ff <= avs_writedata_i[rs_dec_pkg::CFG_LEN_LSB +: 8];
        cfg_check_ff <= avs_writedata_i[rs_dec_pkg::CFG_CHECK_LSB +: 5];
        cfg_thr_ff <= avs_writedata_i[rs_dec_pkg::CFG_THR_LSB +: 5];
        cfg_ctrl_ff <= avs_writedata_i[rs_dec_pkg::CFG_CTRL_LSB +: 4];
      end
    end else if (cfg_take && init_idx_ff != rs_dec_pkg::INIT_IDX_DONE) begin
      init_idx_ff <= 3'(init_idx_ff + 3'h1);
      case (init_idx_ff)
        rs_dec_pkg::INIT_IDX_LEN: cfg_len_ff <= input_byte_bus_i;
        rs_dec_pkg::INIT_IDX_CHECK: cfg_check_ff <= input_byte_bus_i[4:0];
        rs_dec_pkg::INIT_IDX_THR: cfg_thr_ff <= input_byte_bus_i[4:0];
        rs_dec_pkg::INIT_IDX_CTRL: cfg_ctrl_ff <= input_byte_bus_i[3:0];
        default: cfg_ctrl_ff <= cfg_ctrl_ff;
      endcase
    end
  end

  // Avalon-MM slave: waitrequest drops one cycle after the request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if ((avs_read_i | avs_write_i) & wait_ff) begin
      wait_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      if (avs_read_i) begin
        case (avs_address_i)
          rs_dec_pkg::ADDR_CONFIG: begin
            rdata_ff[rs_dec_pkg::CFG_LEN_LSB +: 8] <= cfg_len_ff;
            rdata_ff[rs_dec_pkg::CFG_CHECK_LSB +: 5] <= cfg_check_ff;
            rdata_ff[rs_dec_pkg::CFG_THR_LSB +: 5] <= cfg_thr_ff;
            rdata_ff[rs_dec_pkg::CFG_CTRL_LSB +: 4] <= cfg_ctrl_ff;
          end
          rs_dec_pkg::ADDR_STATUS: begin
            rdata_ff[rs_dec_pkg::STS_ERS_LSB +: 6] <= ers_ff;
            rdata_ff[rs_dec_pkg::STS_DEG_LSB +: 6] <= deg_ff;
            rdata_ff[rs_dec_pkg::STS_STATE_LSB +: 3] <= state_ff;
            rdata_ff[rs_dec_pkg::STS_FLAG_BIT] <= flag_n_ff;
            rdata_ff[rs_dec_pkg::STS_DISCARD_BIT] <= discard_ff;
          end
          rs_dec_pkg::ADDR_BLOCKS: rdata_ff[15:0] <= blocks_ff;
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // Syndromes accumulate by Horner as data bytes arrive
  for (genvar j = 0; j < MAX_R; j++) begin : g_syn
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        syn_ff[j] <= 8'h00;
      end else if (!init_reset_n_i || out_done) begin
        syn_ff[j] <= 8'h00;
      end else if (data_take) begin
        syn_ff[j] <= rs_dec_pkg::gf_mul(syn_ff[j], root_w[j]) ^ input_byte_bus_i;
      end
    end
  end

  // Decode sequencer; single buffer, so input stalls until the block is read out
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= rs_dec_pkg::ST_LOAD;
      ready_ff <= 1'b1;
      idx_ff <= 8'h00;
      k_ff <= 5'h00;
      ers_ff <= 6'h00;
      era_used_ff <= 6'h00;
      deg_ff <= 6'h00;
      root_cnt_ff <= 6'h00;
      xpow_ff <= 8'h01;
      xb_ff <= 8'h01;
      discard_ff <= 1'b0;
      blocks_ff <= 16'h0000;
      mem_ff <= '{default: 8'h00};
      mark_ff <= '{default: 1'b0};
      lam_ff <= '{default: 8'h00};
      bpoly_ff <= '{default: 8'h00};
      omg_ff <= '{default: 8'h00};
    end else if (!init_reset_n_i) begin
      state_ff <= rs_dec_pkg::ST_LOAD;
      ready_ff <= 1'b1;
      idx_ff <= 8'h00;
    end else begin
      case (state_ff)
        rs_dec_pkg::ST_LOAD: begin
          if (data_take) begin
            mem_ff[idx_ff] <= input_byte_bus_i;
            mark_ff[idx_ff] <= erasure_mark_i;
            if (idx_ff == 8'(cfg_len_ff - 8'h01)) begin
              ready_ff <= 1'b0;
              state_ff <= rs_dec_pkg::ST_ERAS;
              xpow_ff <= 8'h01;
              ers_ff <= 6'h00;
              lam_ff <= '{0: 8'h01, default: 8'h00};
            end else begin
              idx_ff <= 8'(idx_ff + 8'h01);
            end
          end
        end
        rs_dec_pkg::ST_ERAS: begin
          // Erasure locator built from degree 0 upward
          if (mark_ff[idx_ff]) begin
            if (ers_ff <= 6'(MAX_R)) begin
              ers_ff <= 6'(ers_ff + 6'h01);
            end
            if (ers_ff < 6'(MAX_R)) begin
              for (int i = 1; i <= MAX_R; i++) begin
                lam_ff[i] <= lam_ff[i] ^ rs_dec_pkg::gf_mul(xpow_ff, lam_ff[i-1]);
              end
            end
          end
          xpow_ff <= rs_dec_pkg::gf_mul(xpow_ff, rs_dec_pkg::GF_ALPHA);
          if (idx_ff == 8'h00) begin
            state_ff <= rs_dec_pkg::ST_SETUP;
          end else begin
            idx_ff <= 8'(idx_ff - 8'h01);
          end
        end
        rs_dec_pkg::ST_SETUP: begin
          omg_ff <= '{default: 8'h00};
          if (ers_ff > 6'(peff)) begin
            discard_ff <= 1'b1;
            era_used_ff <= 6'h00;
            deg_ff <= 6'h00;
            k_ff <= 5'h00;
            lam_ff <= '{0: 8'h01, default: 8'h00};
            bpoly_ff <= '{0: 8'h01, default: 8'h00};
          end else begin
            discard_ff <= 1'b0;
            era_used_ff <= ers_ff;
            deg_ff <= ers_ff;
            k_ff <= 5'(ers_ff);
            bpoly_ff <= lam_ff;
          end
          state_ff <= rs_dec_pkg::ST_BM;
        end
        rs_dec_pkg::ST_BM: begin
          if (k_ff >= cfg_check_ff) begin
            state_ff <= rs_dec_pkg::ST_OMEGA;
            k_ff <= 5'h00;
          end else begin
            k_ff <= 5'(k_ff + 5'h01);
            if (conv_val != 8'h00) begin
              for (int i = 1; i <= MAX_R; i++) begin
                lam_ff[i] <= lam_ff[i] ^ rs_dec_pkg::gf_mul(conv_val, bpoly_ff[i-1]);
              end
            end
            if (conv_val != 8'h00 && 7'({deg_ff, 1'b0}) <= 7'(k_ff) + 7'(era_used_ff)) begin
              deg_ff <= 6'(6'(k_ff) + 6'h01 + era_used_ff - deg_ff);
              for (int i = 0; i <= MAX_R; i++) begin
                bpoly_ff[i] <= rs_dec_pkg::gf_mul(rs_dec_pkg::gf_inv(conv_val), lam_ff[i]);
              end
            end else begin
              bpoly_ff[0] <= 8'h00;
              for (int i = 1; i <= MAX_R; i++) begin
                bpoly_ff[i] <= bpoly_ff[i-1];
              end
            end
          end
        end
        rs_dec_pkg::ST_OMEGA: begin
          omg_ff[k_ff] <= conv_val;
          k_ff <= 5'(k_ff + 5'h01);
          if (k_ff == 5'(cfg_check_ff - 5'h01)) begin
            state_ff <= rs_dec_pkg::ST_CHIEN;
            idx_ff <= 8'(cfg_len_ff - 8'h01);
            xb_ff <= 8'h01;
            root_cnt_ff <= 6'h00;
          end
        end
        rs_dec_pkg::ST_CHIEN: begin
          for (int i = 0; i <= MAX_R; i++) begin
            lam_ff[i] <= rs_dec_pkg::gf_mul(lam_ff[i], ainv_w[i]);
            if (i < MAX_R) begin
              omg_ff[i] <= rs_dec_pkg::gf_mul(omg_ff[i], ainv_w[i]);
            end
          end
          xb_ff <= rs_dec_pkg::gf_mul(xb_ff, AINV_FCR);
          if (is_root) begin
            root_cnt_ff <= 6'(root_cnt_ff + 6'h01);
          end
          // Written even if the block later fails
          mem_ff[idx_ff] <= err_val ^
            (cfg_ctrl_ff[rs_dec_pkg::CTRL_CORR_VEC] ? 8'h00 : mem_ff[idx_ff]);
          if (idx_ff == 8'h00) begin
            state_ff <= rs_dec_pkg::ST_JUDGE;
          end else begin
            idx_ff <= 8'(idx_ff - 8'h01);
          end
        end
        rs_dec_pkg::ST_JUDGE: begin
          blocks_ff <= 16'(blocks_ff + 16'h0001);
          state_ff <= rs_dec_pkg::ST_OUT;
        end
        rs_dec_pkg::ST_OUT: begin
          if (out_done) begin
            state_ff <= rs_dec_pkg::ST_LOAD;
            idx_ff <= 8'h00;
            ready_ff <= 1'b1;
          end
        end
        default: state_ff <= rs_dec_pkg::ST_LOAD;
      endcase
    end
  end

  // Output port; flag set with the first byte, held through the last
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_ff <= 1'b0;
      dout_ff <= 8'h00;
      optr_ff <= 8'h00;
      flag_n_ff <= 1'b1;
    end else if (!init_reset_n_i) begin
      valid_ff <= 1'b0;
    end else if (state_ff == rs_dec_pkg::ST_JUDGE) begin
      valid_ff <= 1'b1;
      optr_ff <= out_first;
      dout_ff <= mem_ff[out_first];
      flag_n_ff <= judge_fail;
    end else if (valid_ff && output_ack_i) begin
      if (optr_ff == out_last) begin
        valid_ff <= 1'b0;
      end else begin
        optr_ff <= out_next;
        dout_ff <= mem_ff[out_next];
      end
    end
  end

  // All state is plain flip-flops, so a stopped clock loses nothing
  assign input_ready_o = ready_ff;
  assign output_byte_bus_o = dout_ff;
  assign output_valid_o = valid_ff;
  assign correctable_flag_n_o = flag_n_ff;
  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;

endmodule : rs_decoder_io_and_erasure_control

//--- test/rs_dec_properties.sv
// Port checker for the RS decoder: handshakes, flag and decode bounds.
// Assumes one clock domain; bound onto every decoder instance.
`timescale 1ns/1ps
module rs_dec_checker (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic init_reset_n_i,
  input wire logic input_strobe_n_i,
  input wire logic input_ready_o,
  input wire logic [7:0] output_byte_bus_o,
  input wire logic output_valid_o,
  input wire logic output_ack_i,
  input wire logic correctable_flag_n_o,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_out_holds: assert property (
    output_valid_o && !output_ack_i && init_reset_n_i |=>
    output_valid_o && $stable(output_byte_bus_o)) else $error("output byte left without ack");
  a_busy_no_input: assert property (
    output_valid_o |-> !input_ready_o) else $error("input ready during output");
  a_ready_fall: assert property (
    $fell(input_ready_o) |-> !$past(input_strobe_n_i) && $past(init_reset_n_i))
    else $error("ready fell without an accepted byte");
  a_last_ack: assert property (
    $fell(output_valid_o) && $past(init_reset_n_i) |-> $past(output_ack_i) && input_ready_o)
    else $error("output ended without ack");
  a_flag_steady: assert property (
    output_valid_o && $past(output_valid_o) |-> $stable(correctable_flag_n_o))
    else $error("flag changed within a block");
  a_init_clears: assert property (
    !init_reset_n_i |=> input_ready_o && !output_valid_o) else $error("init did not clear");
  a_decode_bound: assert property (disable iff (!arst_n_i || !init_reset_n_i)
    $fell(input_ready_o) |-> ##[1:700] output_valid_o) else $error("no output after block");
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered");
  c_ack_taken: cover property (output_valid_o && output_ack_i);
  c_flag_high: cover property ($rose(correctable_flag_n_o));
  c_strobe_refused: cover property (!input_ready_o && !input_strobe_n_i && init_reset_n_i);
endmodule : rs_dec_checker

bind rs_decoder_io_and_erasure_control rs_dec_checker rs_dec_checker_i (
  .sys_clk_i, .arst_n_i, .init_reset_n_i, .input_strobe_n_i, .input_ready_o,
  .output_byte_bus_o, .output_valid_o, .output_ack_i, .correctable_flag_n_o,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o);

//--- test/rs_host_sink.sv
// Host sink model: acknowledges output bytes, records byte and flag per ack.
// Assumes active-high valid and ack; stall_i gives idle cycles between acks.
`timescale 1ns/1ps
module rs_host_sink (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic valid_i,
  input wire logic [7:0] byte_i,
  input wire logic flag_n_i,
  input wire logic [3:0] stall_i,
  output logic ack_o
);
  logic [3:0] wait_ff;
  logic [7:0] got_q[$];
  logic flg_q[$];

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_o <= 1'b0;
      wait_ff <= 4'h0;
    end else if (valid_i && ack_o) begin
      got_q.push_back(byte_i);
      flg_q.push_back(flag_n_i);
      // Zero stall leaves ack up past the block end, probing the ignore case
      ack_o <= (stall_i == 4'h0);
      wait_ff <= stall_i;
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else if (valid_i) begin
      ack_o <= 1'b1;
    end
  end
endmodule : rs_host_sink

//--- test/rs_decoder_io_and_erasure_control_tb.sv
// Self-checking bench for the RS decoder: init bytes, blocks, output order, flag.
// Assumes the host sink acks outputs; all-zero codewords need no encoder.
`timescale 1ns/1ps
module rs_decoder_io_and_erasure_control_tb;
  localparam int BN = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic init_n = 1'b1;
  logic strobe_n = 1'b1;
  logic [7:0] din = 8'h00;
  logic ers = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] stall = 4'h0;
  logic ack;
  logic ready;
  logic valid;
  logic flag_n;
  logic wait_rq;
  logic [7:0] dout;
  logic [31:0] rdata;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  rs_decoder_io_and_erasure_control rs_decoder_io_and_erasure_control_i (
    .sys_clk_i(clk), .arst_n_i(rst_n), .init_reset_n_i(init_n), .input_strobe_n_i(strobe_n),
    .input_byte_bus_i(din), .erasure_mark_i(ers), .input_ready_o(ready),
    .output_byte_bus_o(dout), .output_valid_o(valid), .output_ack_i(ack),
    .correctable_flag_n_o(flag_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_rq));
  rs_host_sink rs_host_sink_i (.sys_clk_i(clk), .arst_n_i(rst_n), .valid_i(valid),
    .byte_i(dout), .flag_n_i(flag_n), .stall_i(stall), .ack_o(ack));

  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_rq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av

  task automatic init_cfg(input logic [7:0] n, r, p, c);
    logic [7:0] b [4];
    b = '{n, r, p, c};
    @(posedge clk);
    init_n <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (b[i]) begin
      strobe_n <= 1'b0;
      din <= b[i];
      @(posedge clk);
    end
    strobe_n <= 1'b1;
    @(posedge clk);
    init_n <= 1'b1;
  endtask : init_cfg

  task automatic blk(input logic [79:0] d, input logic [9:0] e, input logic [47:0] x,
                     input logic fl, input int fi);
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    for (int i = 0; i < BN; i++) begin
      strobe_n <= 1'b0;
      din <= d[8*i+:8];
      ers <= e[i];
      @(posedge clk);
    end
    // Stray byte while not ready must leave no trace
    din <= 8'hA5;
    ers <= 1'b1;
    @(posedge clk);
    chk("ready after block", {31'h0, ready}, 32'h0);
    strobe_n <= 1'b1;
    ers <= 1'b0;
    while (rs_host_sink_i.got_q.size() < 6) @(posedge clk);
    // Failed blocks carry no trustworthy bytes
    for (int i = 0; i < 6 && !fl; i++)
      chk("out byte", {24'h0, rs_host_sink_i.got_q[i]}, {24'h0, x[8*i+:8]});
    chk("flag_n", {31'h0, rs_host_sink_i.flg_q[fi]}, {31'h0, fl});
    rs_host_sink_i.got_q.delete();
    rs_host_sink_i.flg_q.delete();
  endtask : blk

  task automatic s_thr_above();
    logic [31:0] q;
    init_cfg(8'h0A, 8'h04, 8'h1E, 8'h00);
    av(1'b0, rs_dec_pkg::ADDR_CONFIG, 32'h0, q);
    chk("config", q, 32'h001E040A);
    av(1'b1, 4'hC, 32'hFFFFFFFF, q);
    av(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", q, 32'h0);
    blk(80'h44332211, 10'h00F, 48'h0, 1'b0, 0);
    // Five marks exceed the clamped threshold but not the programmed one
    blk(80'h44332211, 10'h01F, 48'h0, 1'b1, 0);
  endtask : s_thr_above

  task automatic s_two_errors();
    stall <= 4'h2;
    blk(80'h0000C3000000005A0000, 10'h000, 48'h0, 1'b0, 0);
    stall <= 4'h0;
  endtask : s_two_errors

  task automatic s_excess_ers();
    init_cfg(8'h0A, 8'h04, 8'h04, 8'h00);
    blk(80'h0, 10'h01F, 48'h0, 1'b1, 0);
    init_cfg(8'h0A, 8'h04, 8'h04, 8'h01);
    blk(80'h0, 10'h01F, 48'h0, 1'b0, 0);
  endtask : s_excess_ers

  task automatic s_low_thr();
    init_cfg(8'h0A, 8'h04, 8'h01, 8'h00);
    // One mark within threshold plus one unmarked error: fits R, not P
    blk(80'h2211, 10'h001, 48'h0, 1'b1, 0);
  endtask : s_low_thr

  task automatic s_vec_rev();
    logic [31:0] q;
    init_cfg(8'h0A, 8'h04, 8'h04, 8'h06);
    blk(80'h7700, 10'h000, 48'h007700000000, 1'b0, 5);
    av(1'b0, rs_dec_pkg::ADDR_STATUS, 32'h0, q);
    chk("status", q, 32'h00000100);
    av(1'b0, rs_dec_pkg::ADDR_BLOCKS, 32'h0, q);
    chk("blocks", q, 32'h00000007);
    av(1'b1, rs_dec_pkg::ADDR_CONFIG, 32'h0103040A, q);
    av(1'b0, rs_dec_pkg::ADDR_CONFIG, 32'h0, q);
    chk("config write", q, 32'h0103040A);
  endtask : s_vec_rev

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_thr_above();
    s_two_errors();
    s_excess_ers();
    s_low_thr();
    s_vec_rev();
    finish_test();
  end
endmodule : rs_decoder_io_and_erasure_control_tb
